/* File: modem_hs_defs.svh */
// Purpose: Constants for the modem-control serial port
// Assumes: 20 MHz reference clock, fixed character format
// Notes:   Definitions only
`ifndef MODEM_HS_DEFS_SVH
`define MODEM_HS_DEFS_SVH

`define CLK_HZ      20000000
`define BAUD_BPS    9600
// One bit time in clock cycles, rounded down
`define BIT_CYC     (`CLK_HZ / `BAUD_BPS)
`define HALF_CYC    (`BIT_CYC / 2)
`define CNT_W       12
`define DATA_W      8
`define LAST_BIT    3'h7

// Line levels
`define LVL_START   1'h0
`define LVL_STOP    1'h1

// Synchroniser lane positions
`define SY_DSR      0
`define SY_DCD      1
`define SY_CTS      2
`define SY_RXD      3
`define SY_W        4
// Lines idle: handshakes low, data at mark
`define SY_RST      4'h8

`endif

/* File: modem_hs_pkg.sv */
// Purpose: Types shared by the serial port modules
// Assumes: modem_hs_defs.svh included first
// Notes:   State of each module is one packed struct
`include "modem_hs_defs.svh"

package modem_hs_pkg;

  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;

  typedef logic [`CNT_W-1:0] cnt_t;

  typedef struct packed {
    logic [`SY_W-1:0]   sync1;
    logic [`SY_W-1:0]   sync2;
    logic               dtr;
    logic               rts;
    logic               txd;
    logic               tx_ready;
    logic               tx_busy;
    logic               link_up;
    logic               rx_valid;
    logic               rx_ferr;
    logic [`DATA_W-1:0] rx_data;
    logic [`DATA_W-1:0] shreg;
    tx_state_e          tx_st;
    logic [2:0]         bit_idx;
    cnt_t               cyc;
  } port_s;

  typedef struct packed {
    rx_state_e          st;
    logic [2:0]         bit_idx;
    cnt_t               cyc;
    logic [`DATA_W-1:0] shreg;
    logic               valid;
    logic               ferr;
  } deser_s;

  // Bit-time counter step
  function automatic cnt_t cnt_dec(input cnt_t c);
    cnt_dec = c - cnt_t'(1);
  endfunction

  function automatic cnt_t bit_reload();
    bit_reload = cnt_t'(`BIT_CYC - 1);
  endfunction

endpackage

/* File: modem_hs_port.sv */
// Purpose: Terminal-side serial port with DTR/DSR/DCD and RTS/CTS handshake
// Assumes: One 20 MHz clock, synchronous active-high reset
// Notes:   Pins are logic levels, high means asserted (mark for data)
`include "modem_hs_defs.svh"

// Summary of operation
// - The port has one serial data output and one serial data input, one path each way.
// - Pins carry terminal-side meaning, and the far end plays the complementary role.
// - DTR is driven asserted exactly while the port is powered and able to communicate.
// - The peer's ready line seen on DSR decides whether any transmission is allowed.
// - Both ends raise DTR before talking, and which end raises it first does not matter.
// - RTS is asserted when the local receiver can accept data, meaning ready to listen.
// - While CTS is asserted, queued characters are sent one after another.
// - RTS drops when the receiver cannot take more data and returns once it can.
// - With CTS deasserted no new data is sent until CTS is asserted again.
// - The RTS/CTS data exchange starts only with DTR asserted and DSR and DCD seen; RTS here needs only DTR and DSR.
// - DTR and DSR only report equipment status, and per-character flow uses RTS/CTS.
// - Every character is framed by a start bit before its data bits and a stop bit after.
module modem_hs_port
  import modem_hs_pkg::*;
(
  // Clock and reset
  input  wire logic               ref_clk_i,
  input  wire logic               rst_i,
  // Local status
  input  wire logic               power_ok_i,
  input  wire logic               rx_ready_i,
  // Transmit stream
  input  wire logic [`DATA_W-1:0] tx_data_i,
  input  wire logic               tx_valid_i,
  output logic                    tx_ready_o,
  output logic                    tx_busy_o,
  // Receive stream
  output logic [`DATA_W-1:0]      rx_data_o,
  output logic                    rx_valid_o,
  output logic                    rx_ferr_o,
  // Link status
  output logic                    link_up_o,
  // Serial pins
  output logic                    txd_o,
  input  wire logic               rxd_i,
  output logic                    dtr_o,
  input  wire logic               dsr_i,
  input  wire logic               dcd_i,
  output logic                    rts_o,
  input  wire logic               cts_i
);

  localparam port_s PORT_RST = '{
    sync1:    `SY_RST,
    sync2:    `SY_RST,
    dtr:      1'h0,
    rts:      1'h0,
    txd:      `LVL_STOP,
    tx_ready: 1'h0,
    tx_busy:  1'h0,
    link_up:  1'h0,
    rx_valid: 1'h0,
    rx_ferr:  1'h0,
    rx_data:  '0,
    shreg:    '0,
    tx_st:    TX_IDLE,
    bit_idx:  3'h0,
    cyc:      '0
  };

  port_s q_ff;
  port_s nxt_q;

  logic dsr_s;
  logic dcd_s;
  logic cts_s;
  logic ready_ok;
  logic send_ok;
  logic take;

  ser_rx_if rif ();

  // Second synchroniser stage only
  assign dsr_s = q_ff.sync2[`SY_DSR];
  assign dcd_s = q_ff.sync2[`SY_DCD];
  assign cts_s = q_ff.sync2[`SY_CTS];
  assign rif.rxd = q_ff.sync2[`SY_RXD];

  // Equipment status only, not flow control
  assign ready_ok = q_ff.dtr & dsr_s;
  // Character flow needs channel and peer listening
  assign send_ok = ready_ok & dcd_s & cts_s;
  assign take = q_ff.tx_ready & tx_valid_i;

  ser_rx_deser u_deser (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .rx        (rif.deser)
  );

  always_comb begin
    nxt_q = q_ff;

    nxt_q.sync1 = {rxd_i, cts_i, dcd_i, dsr_i};
    nxt_q.sync2 = q_ff.sync1;

    nxt_q.dtr = power_ok_i;
    // Listen-ready, not have-data-to-send
    nxt_q.rts = ready_ok & rx_ready_i;
    nxt_q.link_up = ready_ok & dcd_s;

    nxt_q.rx_valid = rif.valid;
    nxt_q.rx_ferr  = rif.ferr;
    if (rif.valid) begin
      nxt_q.rx_data = rif.data;
    end

    if (q_ff.tx_st != TX_IDLE) begin
      nxt_q.cyc = cnt_dec(q_ff.cyc);
    end

    case (q_ff.tx_st)
      TX_IDLE: begin
        nxt_q.tx_ready = send_ok;
        if (take) begin
          nxt_q.shreg    = tx_data_i;
          nxt_q.tx_st    = TX_START;
          nxt_q.cyc      = bit_reload();
          nxt_q.tx_ready = 1'h0;
        end
      end
      TX_START: begin
        if (q_ff.cyc == '0) begin
          nxt_q.tx_st   = TX_DATA;
          nxt_q.cyc     = bit_reload();
          nxt_q.bit_idx = 3'h0;
        end
      end
      TX_DATA: begin
        // CTS is not looked at mid-character
        if (q_ff.cyc == '0) begin
          nxt_q.cyc = bit_reload();
          if (q_ff.bit_idx == `LAST_BIT) begin
            nxt_q.tx_st = TX_STOP;
          end else begin
            nxt_q.bit_idx = q_ff.bit_idx + 3'h1;
            nxt_q.shreg   = {1'h0, q_ff.shreg[`DATA_W-1:1]};
          end
        end
      end
      TX_STOP: begin
        if (q_ff.cyc == '0) begin
          nxt_q.tx_st = TX_IDLE;
        end
      end
      default: begin
        nxt_q.tx_st = TX_IDLE;
      end
    endcase

    // Line level follows the next state
    case (nxt_q.tx_st)
      TX_START: nxt_q.txd = `LVL_START;
      TX_DATA:  nxt_q.txd = nxt_q.shreg[0];
      default:  nxt_q.txd = `LVL_STOP;
    endcase

    nxt_q.tx_busy = (nxt_q.tx_st != TX_IDLE);
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      q_ff <= PORT_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign tx_ready_o = q_ff.tx_ready;
  assign tx_busy_o  = q_ff.tx_busy;
  assign rx_data_o  = q_ff.rx_data;
  assign rx_valid_o = q_ff.rx_valid;
  assign rx_ferr_o  = q_ff.rx_ferr;
  assign link_up_o  = q_ff.link_up;
  assign txd_o      = q_ff.txd;
  assign dtr_o      = q_ff.dtr;
  assign rts_o      = q_ff.rts;

  // Checks

  default clocking cb @(posedge ref_clk_i);
  endclocking

  default disable iff (rst_i);

  sequence s_accept;
    (q_ff.tx_st == TX_IDLE) && take;
  endsequence

  sequence s_char_end;
    (q_ff.tx_st == TX_STOP) ##1 (q_ff.tx_st == TX_IDLE);
  endsequence

  sequence s_cts_low;
    !cts_i [*3];
  endsequence

  a_dtr_power_follow: assert property (
    $rose(power_ok_i) |=> dtr_o ##0 (dtr_o throughout power_ok_i [*2]) or !power_ok_i
  ) else $error("DTR did not follow power-ok");

  a_dtr_power_drop: assert property (
    !power_ok_i |=> !dtr_o
  ) else $error("DTR stayed high without power-ok");

  a_rts_drop_busy: assert property (
    !rx_ready_i |=> !rts_o
  ) else $error("RTS high while receiver cannot accept");

  a_rts_needs_status: assert property (
    rts_o |-> $past(dtr_o) && $past(dsr_s)
  ) else $error("RTS asserted without DTR and DSR");

  a_rts_listen_ready: assert property (
    (rx_ready_i && dtr_o && dsr_s) |=> rts_o
  ) else $error("RTS not asserted while able to listen");

  a_dsr_gate_send: assert property (
    (!dsr_i [*3]) |=> ##1 !tx_ready_o
  ) else $error("Transmit offered while peer not ready");

  a_cts_stop_send: assert property (
    s_cts_low |=> ##1 !tx_ready_o
  ) else $error("Transmit offered with CTS low");

  a_start_gated_all: assert property (
    s_accept |-> $past(dtr_o) && $past(dsr_s) && $past(dcd_s) && $past(cts_s)
  ) else $error("Character started before the handshake conditions");

  a_start_bit_low: assert property (
    s_accept |=> (txd_o == `LVL_START) [*3]
  ) else $error("Start bit not driven low");

  a_stop_bit_high: assert property (
    (q_ff.tx_st == TX_STOP) |-> (txd_o == `LVL_STOP)
  ) else $error("Stop bit not driven high");

  a_char_finish_ok: assert property (
    (q_ff.tx_st == TX_DATA) |=> (q_ff.tx_st == TX_DATA) || (q_ff.tx_st == TX_STOP)
  ) else $error("Character cut short before its stop bit");

  a_char_end_idle: assert property (
    s_char_end |-> (txd_o == `LVL_STOP) && !tx_ready_o
  ) else $error("Line not idle after a finished character");

  a_cts_sync_delay: assert property (
    ##3 (cts_s == $past(cts_i, 2))
  ) else $error("CTS synchroniser delay wrong");

  a_rxd_sync_delay: assert property (
    ##3 (rif.rxd == $past(rxd_i, 2))
  ) else $error("Receive data synchroniser delay wrong");

  a_rx_valid_pulse: assert property (
    rx_valid_o |=> !rx_valid_o
  ) else $error("Receive valid lasted more than one cycle");

  a_rts_needs_dtr: assert property (
    !dtr_o |=> !rts_o
  ) else $error("RTS asserted before own DTR");

  a_rts_needs_power: assert property (
    !power_ok_i |=> ##1 !rts_o
  ) else $error("RTS asserted without power-ok");

  a_ready_needs_dcd: assert property (
    !dcd_s |=> !tx_ready_o
  ) else $error("Transmit offered without carrier");

  a_link_up_follow: assert property (
    (dtr_o && dsr_s && dcd_s) |=> link_up_o
  ) else $error("Link not reported with all status lines up");

  a_link_drop_dcd: assert property (
    !dcd_s |=> !link_up_o
  ) else $error("Link reported without carrier");

  a_ready_drop_take: assert property (
    s_accept |=> !tx_ready_o && tx_busy_o
  ) else $error("Port still ready after taking a character");

  a_busy_not_ready: assert property (
    tx_busy_o |-> !tx_ready_o
  ) else $error("New character offered during a character");

  a_idle_line_mark: assert property (
    (q_ff.tx_st == TX_IDLE) |-> (txd_o == `LVL_STOP)
  ) else $error("Line not at mark while idle");

  a_rx_pulse_excl: assert property (
    rx_ferr_o |-> !rx_valid_o
  ) else $error("Framing error and valid together");

  a_rx_data_hold: assert property (
    !rx_valid_o |-> $stable(rx_data_o)
  ) else $error("Receive data changed without valid");

endmodule

/* File: peer_term.sv */
// Purpose: Far terminal at the end of a null-modem cable
// Assumes: Shares the bench clock, same bit time and 8N1 framing
// Notes:   Its RTS drives our CTS, and our DCD while the carrier is up
`include "modem_hs_defs.svh"
module peer_term (
  // Clock
  input  wire logic clk_i,
  // Pins of the far terminal
  input  wire logic rxd_i,
  input  wire logic dsr_i,
  input  wire logic cts_i,
  output logic      txd_o,
  output logic      dtr_o,
  output logic      rts_o,
  output logic      dcd_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic       up_en     = 1'h0;
  logic       listen_en = 1'h0;
  logic       carrier_en = 1'h1;
  logic [7:0] got       = 8'h00;
  logic       got_stop  = 1'h0;
  int         got_cnt   = 0;

  assign dtr_o = up_en;
  assign rts_o = listen_en;
  // Carrier always up on a null-modem cable, a modem may lose it
  assign dcd_o = listen_en & carrier_en;

  initial txd_o = `LVL_STOP;

  task automatic bit_wait(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic send_byte(input logic [7:0] b);
    txd_o = `LVL_START;
    bit_wait(`BIT_CYC);
    for (int i = 0; i < 8; i++) begin
      txd_o = b[i];
      bit_wait(`BIT_CYC);
    end
    txd_o = `LVL_STOP;
    bit_wait(`BIT_CYC);
  endtask

  // Samples each bit at its centre
  always begin
    @(negedge clk_i);
    if (rxd_i === 1'h0) begin
      bit_wait(`HALF_CYC);
      for (int i = 0; i < 8; i++) begin
        bit_wait(`BIT_CYC);
        got[i] = rxd_i;
      end
      bit_wait(`BIT_CYC);
      got_stop = rxd_i;
      got_cnt++;
    end
  end
endmodule

/* File: ser_rx_deser.sv */
// Purpose: Receive deserialiser, start/8 data/stop framing
// Assumes: Synchronised serial input, idle at mark
// Notes:   Samples each bit at its centre
`include "modem_hs_defs.svh"

module ser_rx_deser
  import modem_hs_pkg::*;
(
  // Clock and reset
  input  wire logic   ref_clk_i,
  input  wire logic   rst_i,
  // Port side
  ser_rx_if.deser     rx
);

  localparam deser_s DESER_RST = '{st: RX_IDLE, bit_idx: 3'h0, cyc: '0,
                                   shreg: '0, valid: 1'h0, ferr: 1'h0};

  deser_s q_ff;
  deser_s nxt_q;

  always_comb begin
    nxt_q       = q_ff;
    nxt_q.valid = 1'h0;
    nxt_q.ferr  = 1'h0;
    if (q_ff.st != RX_IDLE) begin
      nxt_q.cyc = cnt_dec(q_ff.cyc);
    end
    case (q_ff.st)
      RX_IDLE: begin
        if (rx.rxd == `LVL_START) begin
          nxt_q.st  = RX_START;
          nxt_q.cyc = cnt_t'(`HALF_CYC - 1);
        end
      end
      RX_START: begin
        if (q_ff.cyc == '0) begin
          // Start bit must still be low at its centre
          nxt_q.st      = (rx.rxd == `LVL_START) ? RX_DATA : RX_IDLE;
          nxt_q.cyc     = bit_reload();
          nxt_q.bit_idx = 3'h0;
        end
      end
      RX_DATA: begin
        if (q_ff.cyc == '0) begin
          nxt_q.shreg   = {rx.rxd, q_ff.shreg[`DATA_W-1:1]};
          nxt_q.cyc     = bit_reload();
          nxt_q.bit_idx = q_ff.bit_idx + 3'h1;
          if (q_ff.bit_idx == `LAST_BIT) begin
            nxt_q.st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (q_ff.cyc == '0) begin
          nxt_q.valid = (rx.rxd == `LVL_STOP);
          nxt_q.ferr  = (rx.rxd != `LVL_STOP);
          nxt_q.st    = RX_IDLE;
        end
      end
      default: nxt_q.st = RX_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      q_ff <= DESER_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign rx.data  = q_ff.shreg;
  assign rx.valid = q_ff.valid;
  assign rx.ferr  = q_ff.ferr;

endmodule

/* File: ser_rx_if.sv */
// Purpose: Carrier between the port logic and its receive deserialiser
// Assumes: Single clock domain
// Notes:   rxd is already synchronised
interface ser_rx_if;
  logic               rxd;
  logic [7:0]         data;
  logic               valid;
  logic               ferr;

  modport host  (output rxd, input data, input valid, input ferr);
  modport deser (input rxd, output data, output valid, output ferr);
endinterface

/* File: tb_top.sv */
// Purpose: Self-checking bench for the modem-control serial port
// Assumes: 20 MHz clock, far terminal on a null-modem cable
// Notes:   Inputs change on the falling edge
`include "modem_hs_defs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic       ref_clk_i  = 1'h0;
  logic       rst_i      = 1'h1;
  logic       power_ok_i = 1'h0;
  logic       rx_ready_i = 1'h0;
  logic [7:0] tx_data_i  = 8'h00;
  logic       tx_valid_i = 1'h0;
  logic       tx_ready_o;
  logic       tx_busy_o;
  logic [7:0] rx_data_o;
  logic       rx_valid_o;
  logic       rx_ferr_o;
  logic       link_up_o;
  logic       txd_o;
  logic       dtr_o;
  logic       rts_o;
  logic       p_txd;
  logic       p_dtr;
  logic       p_rts;
  logic       p_dcd;
  int         failures   = 0;
  int         checks     = 0;

  always #25 ref_clk_i = ~ref_clk_i;

  modem_hs_port modem_hs_port_inst (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .power_ok_i(power_ok_i),
    .rx_ready_i(rx_ready_i),
    .tx_data_i (tx_data_i),
    .tx_valid_i(tx_valid_i),
    .tx_ready_o(tx_ready_o),
    .tx_busy_o (tx_busy_o),
    .rx_data_o (rx_data_o),
    .rx_valid_o(rx_valid_o),
    .rx_ferr_o (rx_ferr_o),
    .link_up_o (link_up_o),
    .txd_o     (txd_o),
    .rxd_i     (p_txd),
    .dtr_o     (dtr_o),
    .dsr_i     (p_dtr),
    .dcd_i     (p_dcd),
    .rts_o     (rts_o),
    .cts_i     (p_rts)
  );

  peer_term peer_term_inst (
    .clk_i(ref_clk_i),
    .rxd_i(txd_o),
    .dsr_i(dtr_o),
    .cts_i(rts_o),
    .txd_o(p_txd),
    .dtr_o(p_dtr),
    .rts_o(p_rts),
    .dcd_o(p_dcd)
  );

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    if (failures == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic hung(input string what);
    check(what, 8'h01, 8'h00);
    report_and_stop;
  endtask

  task automatic wait_ready;
    int n;
    for (n = 0; n < 100 && tx_ready_o !== 1'h1; n++) @(negedge ref_clk_i);
    if (n == 100) hung("tx_ready wait");
  endtask

  task automatic wait_peer(input int cnt);
    int n;
    for (n = 0; n < 25000 && peer_term_inst.got_cnt != cnt; n++) @(negedge ref_clk_i);
    if (n == 25000) hung("peer char wait");
  endtask

  task automatic t_reset;
    check("dtr", dtr_o, 1'h0);
    check("rts", rts_o, 1'h0);
    check("txd", txd_o, 1'h1);
    check("tx_ready", tx_ready_o, 1'h0);
  endtask

  // Peer raises DTR first; order must not matter
  task automatic t_status;
    peer_term_inst.up_en = 1'h1;
    rx_ready_i = 1'h1;
    repeat (5) @(negedge ref_clk_i);
    check("rts no dtr", rts_o, 1'h0);
    power_ok_i = 1'h1;
    @(negedge ref_clk_i);
    check("dtr up", dtr_o, 1'h1);
    repeat (2) @(negedge ref_clk_i);
    check("rts up", rts_o, 1'h1);
    rx_ready_i = 1'h0;
    @(negedge ref_clk_i);
    check("rts busy", rts_o, 1'h0);
    rx_ready_i = 1'h1;
    @(negedge ref_clk_i);
    check("rts again", rts_o, 1'h1);
    peer_term_inst.up_en = 1'h0;
    repeat (4) @(negedge ref_clk_i);
    check("rts no dsr", rts_o, 1'h0);
    peer_term_inst.up_en = 1'h1;
    repeat (4) @(negedge ref_clk_i);
  endtask

  // Data offered while the far end is not listening, which holds our DCD and CTS low
  task automatic t_gate;
    tx_data_i = 8'h3C;
    tx_valid_i = 1'h1;
    repeat (10) @(negedge ref_clk_i);
    check("ready no dcd", tx_ready_o, 1'h0);
    check("link no dcd", link_up_o, 1'h0);
    check("txd held", txd_o, 1'h1);
  endtask

  // Peer listens but the carrier is lost, then comes back
  task automatic t_carrier;
    tx_valid_i = 1'h0;
    peer_term_inst.carrier_en = 1'h0;
    peer_term_inst.listen_en = 1'h1;
    repeat (6) @(negedge ref_clk_i);
    check("ready no carrier", tx_ready_o, 1'h0);
    check("link no carrier", link_up_o, 1'h0);
    check("rts no carrier", rts_o, 1'h1);
    peer_term_inst.carrier_en = 1'h1;
    wait_ready;
    check("link carrier", link_up_o, 1'h1);
    peer_term_inst.listen_en = 1'h0;
    repeat (4) @(negedge ref_clk_i);
    check("ready cts low", tx_ready_o, 1'h0);
    tx_valid_i = 1'h1;
  endtask

  // CTS drops mid-character, then returns
  task automatic t_stall;
    int bad;
    bad = 0;
    peer_term_inst.listen_en = 1'h1;
    wait_ready;
    @(negedge ref_clk_i);
    tx_data_i = 8'hC3;
    repeat (5 * `BIT_CYC) @(negedge ref_clk_i);
    check("busy mid", tx_busy_o, 1'h1);
    peer_term_inst.listen_en = 1'h0;
    wait_peer(1);
    check("char cut", peer_term_inst.got, 8'h3C);
    check("stop bit", peer_term_inst.got_stop, 1'h1);
    repeat (3 * `BIT_CYC) begin
      @(negedge ref_clk_i);
      if (tx_ready_o !== 1'h0 || txd_o !== 1'h1) bad++;
    end
    check("held off", (bad == 0) ? 8'h00 : 8'hFF, 8'h00);
    check("busy done", tx_busy_o, 1'h0);
    peer_term_inst.listen_en = 1'h1;
    wait_ready;
    @(negedge ref_clk_i);
    tx_valid_i = 1'h0;
    wait_peer(2);
    check("resumed", peer_term_inst.got, 8'hC3);
  endtask

  task automatic t_rx;
    int n;
    int ferr;
    ferr = 0;
    fork
      peer_term_inst.send_byte(8'h96);
      begin
        for (n = 0; n < 25000 && rx_valid_o !== 1'h1; n++) begin
          @(negedge ref_clk_i);
          if (rx_ferr_o !== 1'h0) ferr++;
        end
        if (n == 25000) hung("rx wait");
        check("rx data", rx_data_o, 8'h96);
        check("rx ferr", (ferr == 0) ? 8'h00 : 8'hFF, 8'h00);
      end
    join
  endtask

  initial begin
    repeat (2) @(negedge ref_clk_i);
    rst_i = 1'h0;
    @(negedge ref_clk_i);
    t_reset;
    t_status;
    t_gate;
    t_carrier;
    t_stall;
    t_rx;
    report_and_stop;
  end
endmodule
